// ==== rtl/psr_reporter.v ====
// Position status reporter: forms status, alert and marker words and the
// position, Y and velocity outputs from decoded read head results.
// Assumes the decoder presents one result per sample_valid pulse.
//
// Notes on behaviour
// - On fault, X word carries the error number instead of position.
// - Error code in low sixteen X bits, upper bits zero.
// - Status bits: fault, no position, alert, marker; higher bits zero.
// - No position sets flag and zeroes Y, velocity and, when no fault is reported, X.
// - Error priority: internal above 1000, then tipped code 1, then ambiguous code 2.
// - Marker number unsigned in low ten bits, upper six bits zero.
// - Each alert bit follows its condition.
// - Alert order: foreign, close, far, Y big, Y small, tipped, contrast, repair, hot.
// - No condition means alert word is all zero.
// - Entering a repair tape raises the marker flag.
// - On repair tape, position is last absolute plus tape increment.
// - Starting on repair tape without absolute position reports an error.
// - In a marker, position is last absolute plus marker offset.
// - Marker numbers 1 to 999 accepted.
// - Entering a marker raises the marker flag.
// - Event output matches one number, any event, or a listed number.
// - Automatic trigger acquires every 0.025 s.
// - X is 32-bit two's complement, low byte first on the byte port.
// - Unknown speed reports 65535.
`timescale 1ns/100ps
`default_nettype none
`include "psr_consts.vh"
module psr_reporter #(
   parameter integer TRIG_CYCLES = `PSR_TRIG_CYCLES,
   parameter integer LIST_LEN = 4
) (
   // Clock and reset
   input wire mclk,
   input wire srst,
   // Configuration
   input wire auto_mode,
   input wire [1:0] event_select,
   input wire [9:0] event_match,
   input wire [10*LIST_LEN-1:0] event_list,
   // Decoded sample from the image decoder
   input wire sample_valid,
   input wire pos_found,
   input wire abs_code,
   input wire repair_code,
   input wire marker_code,
   input wire signed [31:0] abs_position,
   input wire signed [31:0] incr_offset,
   input wire [9:0] marker_id,
   input wire signed [31:0] y_in,
   input wire speed_known,
   input wire [31:0] speed_in,
   input wire [15:0] internal_err,
   input wire tipped_180,
   input wire ambiguous,
   input wire [8:0] alert_cond,
   // Byte port for the X word
   input wire [1:0] x_byte_sel,
   // Trigger towards the decoder
   output reg acquire,
   // Cyclic input words
   output reg [15:0] head_status_word,
   output reg [15:0] last_marker_number,
   output reg [15:0] active_alert_flags,
   output reg signed [31:0] x_coordinate,
   output reg signed [31:0] y_coordinate,
   output reg [31:0] velocity_value,
   output reg [7:0] x_byte,
   output reg event_out
);
   ////////////////////////////////////////////////////////////////////////////
   wire trig_pulse;
   wire [LIST_LEN-1:0] list_match;
   wire [15:0] next_alerts;
   reg signed [31:0] last_abs;
   reg abs_known;
   reg [15:0] next_err;
   reg next_fault;
   reg signed [31:0] next_pos;
   reg next_inrange;
   reg marker_ok;
   reg alert_any;
   reg list_hit;
   reg one_hit;
   reg next_event;
   reg [15:0] next_status;
   reg signed [31:0] next_x;
   reg signed [31:0] next_y;
   reg [31:0] next_vel;
   reg [7:0] next_byte;
   genvar g;
   genvar e;

   psr_trigger #(.PERIOD(TRIG_CYCLES)) u_trig (
      .mclk(mclk),
      .srst(srst),
      .auto_mode(auto_mode),
      .trig_pulse(trig_pulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Marker acceptance and range detection.
   // Numbers outside 1 to 999 are treated as plain reel, so a misread marker
   // neither raises the range flag nor replaces the stored number.
   always @* begin
      marker_ok = marker_code && (marker_id >= `PSR_MARKER_MIN) && (marker_id <= `PSR_MARKER_MAX);
      next_inrange = repair_code || marker_ok;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error selection by priority.
   always @* begin
      next_err = 16'h0;
      if (internal_err > `PSR_ERR_INTERNAL_MIN) begin
         next_err = internal_err;
      end else if (tipped_180) begin
         next_err = `PSR_ERR_TIPPED;
      end else if (ambiguous) begin
         next_err = `PSR_ERR_AMBIGUOUS;
      end else if (pos_found && next_inrange && !abs_code && !abs_known) begin
         // An offset tape with no base reading cannot give a position.
         next_err = `PSR_ERR_REPAIR_START;
      end
      next_fault = (next_err != 16'h0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Position source.
   always @* begin
      // Inside a range the tape carries only an offset, so the last reading of
      // the main reel taken outside any range serves as the base.
      if (pos_found && next_inrange && !abs_code) begin
         next_pos = last_abs + incr_offset;
      end else begin
         next_pos = abs_position;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alert word: one bit per condition, reserved bits tied low.
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_alert
         if (g < `PSR_AL_USED) begin : g_used
            assign next_alerts[g] = alert_cond[g];
         end else begin : g_rsvd
            assign next_alerts[g] = 1'b0;
         end
      end
   endgenerate

   always @* begin
      alert_any = (alert_cond != 9'h0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status word assembly; every bit not named here reads zero.
   always @* begin
      next_status = 16'h0;
      next_status[`PSR_ST_FAULT] = next_fault;
      next_status[`PSR_ST_NOPOS] = !pos_found;
      next_status[`PSR_ST_ALERT] = alert_any;
      next_status[`PSR_ST_MARKER] = next_inrange;
   end

   ////////////////////////////////////////////////////////////////////////////
   // X word: an error number takes precedence over any position.
   always @* begin
      if (next_fault) begin
         next_x = {16'h0, next_err};
      end else if (!pos_found) begin
         next_x = 32'sh0;
      end else begin
         next_x = next_pos;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Y and velocity words.
   always @* begin
      if (!pos_found) begin
         next_y = 32'sh0;
         next_vel = 32'h0;
      end else begin
         next_y = y_in;
         next_vel = speed_known ? speed_in : `PSR_SPEED_UNKNOWN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte port: picks one byte of the standing X word, byte 0 the lowest.
   always @* begin
      case (x_byte_sel)
         2'h0: next_byte = x_coordinate[7:0];
         2'h1: next_byte = x_coordinate[15:8];
         2'h2: next_byte = x_coordinate[23:16];
         default: next_byte = x_coordinate[31:24];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event list comparison, one comparator per list entry.
   generate
      for (e = 0; e < LIST_LEN; e = e + 1) begin : g_list
         assign list_match[e] = (event_list[10*e +: 10] == last_marker_number[9:0]);
      end
   endgenerate

   // Event output decision, taken from the registered words so that the
   // output follows what the controller reads in the status one cycle later.
   always @* begin
      list_hit = |list_match;
      one_hit = (last_marker_number[9:0] == event_match);
      if (!head_status_word[`PSR_ST_MARKER]) begin
         next_event = 1'b0;
      end else if (event_select == `PSR_EVSEL_ANY) begin
         next_event = 1'b1;
      end else if (event_select == `PSR_EVSEL_ONE) begin
         next_event = one_hit;
      end else if (event_select == `PSR_EVSEL_LIST) begin
         next_event = list_hit;
      end else begin
         next_event = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Acquisition pulse towards the decoder.
   always @(posedge mclk) begin
      if (srst) begin
         acquire <= 1'b0;
      end else begin
         acquire <= trig_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Base position tracking.
   // Only an absolute reading outside any range may become the base, so a
   // long repair stretch never builds its offset on top of itself.
   always @(posedge mclk) begin
      if (srst) begin
         last_abs <= 32'sh0;
         abs_known <= 1'b0;
      end else if (sample_valid && pos_found && abs_code && !next_inrange) begin
         last_abs <= abs_position;
         abs_known <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The last accepted marker number is kept after the marker is left.
   always @(posedge mclk) begin
      if (srst) begin
         last_marker_number <= 16'h0;
      end else if (sample_valid && marker_ok) begin
         last_marker_number <= {6'h0, marker_id};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cyclic input words change only with a new sample, so the controller
   // always reads one consistent set between two samples.
   always @(posedge mclk) begin
      if (srst) begin
         head_status_word <= 16'h0;
         active_alert_flags <= 16'h0;
         x_coordinate <= 32'sh0;
         y_coordinate <= 32'sh0;
         velocity_value <= 32'h0;
      end else if (sample_valid) begin
         head_status_word <= next_status;
         active_alert_flags <= next_alerts;
         x_coordinate <= next_x;
         y_coordinate <= next_y;
         velocity_value <= next_vel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte port register.
   always @(posedge mclk) begin
      if (srst) begin
         x_byte <= 8'h0;
      end else begin
         x_byte <= next_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event output register.
   always @(posedge mclk) begin
      if (srst) begin
         event_out <= 1'b0;
      end else begin
         event_out <= next_event;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
endmodule // psr_reporter
`default_nettype wire

// ==== rtl/psr_consts.vh ====
// Constants for the position status reporter: word layouts, codes and timing.
// Assumes inclusion by bare name from the rtl folder.
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH
// Status word bit positions (bit 1 of the word is index 0).
`define PSR_ST_FAULT 0
`define PSR_ST_NOPOS 1
`define PSR_ST_ALERT 2
`define PSR_ST_MARKER 3
// Alert bit positions.
`define PSR_AL_FOREIGN 0
`define PSR_AL_CLOSE 1
`define PSR_AL_FAR 2
`define PSR_AL_YBIG 3
`define PSR_AL_YSMALL 4
`define PSR_AL_TIPPED 5
`define PSR_AL_CONTRAST 6
`define PSR_AL_REPAIR 7
`define PSR_AL_HOT 8
`define PSR_AL_USED 9
// Error codes and limits.
`define PSR_ERR_INTERNAL_MIN 16'd1000
`define PSR_ERR_TIPPED 16'h0001
`define PSR_ERR_AMBIGUOUS 16'h0002
`define PSR_ERR_REPAIR_START 16'h0003
`define PSR_MARKER_MIN 10'd1
`define PSR_MARKER_MAX 10'd999
`define PSR_SPEED_UNKNOWN 32'h0000ffff
// Event output select modes.
`define PSR_EVSEL_ONE 2'h0
`define PSR_EVSEL_ANY 2'h1
`define PSR_EVSEL_LIST 2'h2
// Automatic trigger period.
`define PSR_CLK_HZ 125000000
`define PSR_TRIG_PERIOD_US 25000
`define PSR_TRIG_CYCLES ((`PSR_CLK_HZ / 1000000) * `PSR_TRIG_PERIOD_US)
`endif

// ==== rtl/psr_trigger.v ====
// Automatic acquisition trigger: one-cycle pulse every trigger period.
// Assumes a free running mclk and synchronous srst.
`timescale 1ns/100ps
`default_nettype none
`include "psr_consts.vh"
module psr_trigger #(
   parameter integer PERIOD = `PSR_TRIG_CYCLES
) (
   // Clock and reset
   input wire mclk,
   input wire srst,
   // Control and pulse
   input wire auto_mode,
   output reg trig_pulse
);
   reg [31:0] count;
   always @(posedge mclk) begin
      if (srst || !auto_mode) begin
         count <= 32'h0;
         trig_pulse <= 1'b0;
      end else if (count == PERIOD - 1) begin
         count <= 32'h0;
         trig_pulse <= 1'b1;
      end else begin
         count <= count + 32'h1;
         trig_pulse <= 1'b0;
      end
   end
endmodule // psr_trigger
`default_nettype wire

// ==== testbench/psr_props.sv ====
// Checker for the position status reporter output words.
// Assumes binding to psr_reporter, one clock mclk, sync reset srst.
`timescale 1ns/100ps
`default_nettype none
module psr_props (
   // Clock and reset
   input wire mclk,
   input wire srst,
   // Watched ports
   input wire sample_valid,
   input wire [15:0] internal_err,
   input wire [8:0] alert_cond,
   input wire acquire,
   input wire [15:0] head_status_word,
   input wire [15:0] last_marker_number,
   input wire [15:0] active_alert_flags,
   input wire signed [31:0] x_coordinate,
   input wire signed [31:0] y_coordinate,
   input wire [31:0] velocity_value
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////
   sequence s_gap;
      acquire ##1 !acquire [*8];
   endsequence
   sequence s_int_err;
      sample_valid && internal_err > 16'd1000;
   endsequence
   AST_ACQ_GAP: assert property (acquire |-> s_gap) else $error("acquire pulse spacing wrong");
   AST_ST_ZERO: assert property (head_status_word[15:4] == 12'h0) else $error("status upper bits set");
   AST_MK_ZERO: assert property (last_marker_number[15:10] == 6'h0) else $error("marker upper bits set");
   AST_AL_FOLLOW: assert property (sample_valid |=> active_alert_flags == {7'h0, $past(alert_cond)})
      else $error("alert word wrong");
   AST_AL_FLAG: assert property (sample_valid && alert_cond != 9'h0 |=> head_status_word[2])
      else $error("alert flag missing");
   AST_ERR_INT: assert property (s_int_err |=> head_status_word[0] && x_coordinate == {16'h0, $past(internal_err)})
      else $error("internal error not reported");
   AST_ERR_HIGH: assert property (head_status_word[0] |-> x_coordinate[31:16] == 16'h0)
      else $error("error word upper bits set");
   AST_NOPOS: assert property (head_status_word[1] && !head_status_word[0] |-> x_coordinate == 0
      && y_coordinate == 0 && velocity_value == 32'h0) else $error("no position outputs not zero");
endmodule // psr_props
`default_nettype wire

// ==== testbench/psr_poller.sv ====
// Controller model: polls the X word one byte at a time, low byte first.
// Assumes x_byte follows x_byte_sel one registered cycle later.
`timescale 1ns/100ps
`default_nettype none
module psr_poller (
   // Clock
   input wire mclk,
   // Byte port
   input wire [7:0] x_byte,
   output logic [1:0] x_byte_sel
);
   initial x_byte_sel = 2'h0;
   task automatic read_x(output logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk) x_byte_sel <= i[1:0];
         @(posedge mclk);
         @(posedge mclk);
         w[8*i+:8] = x_byte;
      end
   endtask
endmodule // psr_poller
`default_nettype wire

// ==== testbench/tb.sv ====
// Testbench for the position status reporter with a polling controller.
// Assumes psr_reporter, psr_poller and psr_props are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic mclk = 1'b0, srst = 1'b1, auto_mode = 1'b0, sample_valid = 1'b0, speed_known = 1'b1;
   logic pos_found = 1'b0, abs_code = 1'b0, repair_code = 1'b0, marker_code = 1'b0;
   logic tipped_180 = 1'b0, ambiguous = 1'b0, acquire, event_out;
   logic signed [31:0] abs_position = 0, incr_offset = 0, y_in = 0, x_coordinate, y_coordinate;
   logic [31:0] speed_in = 32'h0, velocity_value, w;
   logic [15:0] internal_err = 16'h0, head_status_word, last_marker_number, active_alert_flags;
   logic [9:0] marker_id = 10'h0;
   logic [8:0] alert_cond = 9'h0;
   logic [7:0] x_byte;
   logic [1:0] x_byte_sel;
   logic [1:0] event_select = 2'h1;
   logic [9:0] event_match = 10'h0;
   logic [39:0] event_list = 40'h0;
   int miscompares = 0, checks_done = 0;
   always #4 mclk = ~mclk;
   psr_reporter #(.TRIG_CYCLES(10)) dut (.mclk, .srst, .auto_mode, .event_select, .event_match,
      .event_list, .sample_valid, .pos_found, .abs_code, .repair_code, .marker_code, .abs_position,
      .incr_offset, .marker_id, .y_in, .speed_known, .speed_in, .internal_err, .tipped_180, .ambiguous,
      .alert_cond, .x_byte_sel, .acquire, .head_status_word, .last_marker_number, .active_alert_flags,
      .x_coordinate, .y_coordinate, .velocity_value, .x_byte, .event_out);
   psr_poller pol (.mclk, .x_byte, .x_byte_sel);
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // Flags k are pos_found, abs_code, repair_code, marker_code.
   task automatic smp(input logic [3:0] k, input logic [31:0] a, input logic [9:0] id);
      @(posedge mclk);
      {pos_found, abs_code, repair_code, marker_code} <= k;
      abs_position <= a;
      incr_offset <= a;
      y_in <= a;
      speed_in <= a;
      marker_id <= id;
      sample_valid <= 1'b1;
      @(posedge mclk) sample_valid <= 1'b0;
      @(posedge mclk);
      #1;
   endtask
   task automatic rst;
      @(posedge mclk) srst <= 1'b1;
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
   endtask
   task automatic t_pos;
      smp(4'hc, 32'hfffffffb, 10'h0);
      chk("x", 32'hfffffffb, x_coordinate);
      chk("y", 32'hfffffffb, y_coordinate);
      chk("status", 32'h0, head_status_word);
      pol.read_x(w);
      chk("x bytes", 32'hfffffffb, w);
      speed_known <= 1'b0;
      smp(4'hc, 32'h7, 10'h0);
      chk("speed", 32'hffff, velocity_value);
      smp(4'h0, 32'h7, 10'h0);
      chk("status", 32'h2, head_status_word);
      chk("x", 32'h0, x_coordinate | y_coordinate | velocity_value);
      $display("test position done");
   endtask
   task automatic t_err;
      internal_err <= 16'd1001;
      tipped_180 <= 1'b1;
      ambiguous <= 1'b1;
      smp(4'hc, 32'h12345, 10'h0);
      chk("x err", 32'h3e9, x_coordinate);
      chk("status", 32'h1, head_status_word);
      internal_err <= 16'h0;
      smp(4'hc, 32'h12345, 10'h0);
      chk("x err", 32'h1, x_coordinate);
      tipped_180 <= 1'b0;
      smp(4'hc, 32'h12345, 10'h0);
      chk("x err", 32'h2, x_coordinate);
      ambiguous <= 1'b0;
      $display("test errors done");
   endtask
   task automatic t_alert;
      for (int i = 0; i < 10; i++) begin
         alert_cond <= (i < 9) ? 9'h1 << i : 9'h0;
         smp(4'hc, 32'h5, 10'h0);
         chk("alerts", (i < 9) ? 32'h1 << i : 32'h0, active_alert_flags);
         chk("status", (i < 9) ? 32'h4 : 32'h0, head_status_word);
      end
      $display("test alerts done");
   endtask
   task automatic t_mark;
      smp(4'hc, 32'd1000, 10'h0);
      smp(4'h9, 32'd25, 10'd999);
      chk("x", 32'd1025, x_coordinate);
      chk("status", 32'h8, head_status_word);
      chk("number", 32'd999, last_marker_number);
      chk("event", 32'h1, event_out);
      smp(4'h9, 32'd7, 10'h0);
      chk("status", 32'h0, head_status_word);
      chk("number", 32'd999, last_marker_number);
      smp(4'ha, 32'd3, 10'h0);
      chk("x", 32'd1003, x_coordinate);
      chk("status", 32'h8, head_status_word);
      rst();
      smp(4'ha, 32'd3, 10'h0);
      chk("fault", 32'h1, head_status_word[0]);
      $display("test markers done");
   endtask
   // Sets the event output selection at an edge and looks at event_out once it has followed.
   task automatic ev(input logic [1:0] s, input logic [9:0] m, input logic [39:0] l, input logic [31:0] e);
      @(posedge mclk);
      event_select <= s;
      event_match <= m;
      event_list <= l;
      repeat (2) @(posedge mclk);
      #1;
      chk("event", e, event_out);
   endtask
   task automatic t_event;
      speed_known <= 1'b1;
      smp(4'hc, 32'd1000, 10'h0);
      chk("speed", 32'd1000, velocity_value);
      smp(4'h9, 32'd5, 10'd42);
      chk("x", 32'd1005, x_coordinate);
      ev(2'h0, 10'd42, 40'h0, 32'h1);
      ev(2'h0, 10'd41, 40'h0, 32'h0);
      ev(2'h2, 10'd0, {10'd7, 10'd42, 10'd3, 10'd9}, 32'h1);
      ev(2'h2, 10'd0, {10'd7, 10'd43, 10'd3, 10'd9}, 32'h0);
      ev(2'h3, 10'd42, 40'h0, 32'h0);
      ev(2'h1, 10'd0, 40'h0, 32'h1);
      smp(4'h9, 32'd5, 10'd1000);
      chk("status", 32'h0, head_status_word);
      chk("number", 32'd42, last_marker_number);
      ev(2'h1, 10'd0, 40'h0, 32'h0);
      $display("test events done");
   endtask
   task automatic t_trig;
      int n;
      n = 0;
      @(posedge mclk) auto_mode <= 1'b1;
      repeat (35) begin
         @(posedge mclk);
         #1;
         n += acquire;
      end
      chk("pulses", 32'd3, n);
      auto_mode <= 1'b0;
      $display("test trigger done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      rst();
      t_pos();
      t_err();
      t_alert();
      t_mark();
      t_event();
      t_trig();
      print_verdict();
   end
   initial begin
      #24000;
      miscompares++;
      print_verdict();
   end
endmodule // tb
bind psr_reporter psr_props u_props (.mclk, .srst, .sample_valid, .internal_err, .alert_cond, .acquire,
   .head_status_word, .last_marker_number, .active_alert_flags, .x_coordinate, .y_coordinate, .velocity_value);
`default_nettype wire
